// ---- rtl/obpm_pkg.sv ----
// constants and types for the bitmap palette map register bank
// assumes a 100 MHz system clock and an APB master on the register port
`default_nettype none

package obpm_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int          ADDR_W      = 12;     // apb address width
    localparam logic [11:0] MAP_BASE    = 12'h000; // first map register
    localparam logic [11:0] MAP_SPAN    = 12'h040; // 16 map words
    localparam logic [11:0] CTRL_OFF    = 12'h040; // pixel mode control
    localparam logic [11:0] STAT_OFF    = 12'h044; // last lookup status
    localparam int          REG_IDX_LSB = 2;      // word index in paddr
    localparam int          REG_IDX_W   = 4;      // 16 map registers
    localparam int          ENT_IDX_W   = 5;      // window bit + entry

    // ****************************************
    // field layout
    // ****************************************
    localparam int          ENT_W       = 8;      // one palette address
    localparam int          PAIR_W      = 16;     // two entries per word
    localparam int          PIX_W       = 4;      // widest pixel value
    localparam int          MODE_W      = 2;      // mode field width
    localparam int          CTRL_W0_LSB = 0;      // window 0 mode field
    localparam int          CTRL_W1_LSB = 2;      // window 1 mode field
    localparam int          STAT_WIN    = 8;      // window of last lookup
    localparam logic [7:0]  ENT_RST     = 8'h00;  // entry reset value
    localparam logic [3:0]  CTRL_RST    = 4'h0;   // both windows 4-bit

    // ****************************************
    // entry numbers for narrow pixels
    // ****************************************
    localparam logic [3:0]  ENT_ZERO    = 4'h0;
    localparam logic [3:0]  ENT_2B_ONE  = 4'h5;
    localparam logic [3:0]  ENT_2B_TWO  = 4'ha;
    localparam logic [3:0]  ENT_TOP     = 4'hf;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_4BPP = 2'b00,
        MODE_2BPP = 2'b01,
        MODE_1BPP = 2'b10,
        MODE_RSVD = 2'b11                         // treated as 4-bit
    } obpm_mode_t;

    typedef enum logic {
        ST_IDLE  = 1'b0,                          // no read pending
        ST_RDONE = 1'b1                           // read data registered
    } obpm_apb_st_t;

endpackage : obpm_pkg

`default_nettype wire

// ---- rtl/obpm_map_if.sv ----
// carrier between the register bank control and the entry memory
// assumes both ends run on the same system clock
`default_nettype none

interface obpm_map_if;
    logic        wr_en;     // write a map register
    logic [3:0]  wr_reg;    // map register index
    logic [1:0]  wr_strb;   // even / odd entry enables
    logic [15:0] wr_data;   // odd entry high, even entry low
    logic        rd_en;     // bus read of a map register
    logic [3:0]  rd_reg;    // map register index
    logic [15:0] rd_data;   // registered pair
    logic        px_en;     // pixel lookup
    logic [4:0]  px_idx;    // window bit and entry number
    logic [7:0]  px_data;   // registered palette address

    modport ctl (output wr_en, wr_reg, wr_strb, wr_data,
                 output rd_en, rd_reg, px_en, px_idx,
                 input  rd_data, px_data);
    modport mem (input  wr_en, wr_reg, wr_strb, wr_data,
                 input  rd_en, rd_reg, px_en, px_idx,
                 output rd_data, px_data);
endinterface : obpm_map_if

`default_nettype wire

// ---- rtl/obpm_map_mem.sv ----
// entry memory: 32 palette addresses, two windows of sixteen
// assumes one clock; reads return one cycle later from a register
`default_nettype none

module obpm_map_mem (
    input  wire logic clk_sys_i,   // system clock
    input  wire logic rst_n_i,     // synchronous reset, low
    obpm_map_if.mem   mp           // control side
);

    // ****************************************
    // storage
    // ****************************************
    localparam int DEPTH = 2 ** obpm_pkg::ENT_IDX_W;

    logic [obpm_pkg::ENT_W-1:0]  ent_r [DEPTH]; // all entries
    logic [obpm_pkg::PAIR_W-1:0] rd_r;          // bus read data
    logic [obpm_pkg::ENT_W-1:0]  px_r;          // pixel read data
    logic [4:0]                  w_even;        // even entry slot
    logic [4:0]                  w_odd;         // odd entry slot
    logic [4:0]                  r_even;
    logic [4:0]                  r_odd;

    assign w_even = {mp.wr_reg, 1'b0};
    assign w_odd  = {mp.wr_reg, 1'b1};
    assign r_even = {mp.rd_reg, 1'b0};
    assign r_odd  = {mp.rd_reg, 1'b1};

    // entries reset to zero, byte strobes pick the entry
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                ent_r[i] <= obpm_pkg::ENT_RST;
            end
        end else if (mp.wr_en) begin
            if (mp.wr_strb[0]) begin
                ent_r[w_even] <= mp.wr_data[7:0];
            end
            if (mp.wr_strb[1]) begin
                ent_r[w_odd] <= mp.wr_data[15:8];
            end
        end
    end

    // registered read ports, old value on same-cycle write
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_r <= '0;
            px_r <= obpm_pkg::ENT_RST;
        end else begin
            if (mp.rd_en) begin
                rd_r <= {ent_r[r_odd], ent_r[r_even]};
            end
            if (mp.px_en) begin
                px_r <= ent_r[mp.px_idx];
            end
        end
    end

    assign mp.rd_data = rd_r;
    assign mp.px_data = px_r;

    // ****************************************
    // checks
    // ****************************************
    a_even_write: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        mp.wr_en && mp.wr_strb[0] |=>
            ent_r[$past(w_even)] == $past(mp.wr_data[7:0]))
        else $error("even entry not written from low byte");

    a_odd_write: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        mp.wr_en && mp.wr_strb[1] |=>
            ent_r[$past(w_odd)] == $past(mp.wr_data[15:8]))
        else $error("odd entry not written from high byte");

    a_pixel_read: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        mp.px_en |=> px_r == $past(ent_r[mp.px_idx]))
        else $error("pixel lookup returned wrong entry");

endmodule : obpm_map_mem

`default_nettype wire

// ---- rtl/obpm_top.sv ----
// bitmap palette map: apb register bank and pixel to palette lookup
// assumes an apb master on clk_sys_i and a pixel source that presents
// one pixel per valid cycle; the colour table takes clut_* one cycle on
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`default_nettype none

module obpm_top (
    input  wire logic        clk_sys_i,    // 100 MHz system clock
    input  wire logic        rst_n_i,      // synchronous reset, low
    input  wire logic [11:0] paddr_i,      // apb byte address
    input  wire logic        psel_i,       // apb select
    input  wire logic        penable_i,    // apb access phase
    input  wire logic        pwrite_i,     // apb direction
    input  wire logic [31:0] pwdata_i,     // apb write data
    input  wire logic [3:0]  pstrb_i,      // apb byte strobes
    output logic      [31:0] prdata_o,     // apb read data
    output logic             pready_o,     // apb ready
    output logic             pslverr_o,    // unmapped address
    input  wire logic        pix_valid_i,  // bitmap pixel present
    input  wire logic        pix_win_i,    // 0 window 0, 1 window 1
    input  wire logic [3:0]  pix_value_i,  // pixel value, low bits used
    output logic             clut_valid_o, // palette address valid
    output logic      [7:0]  clut_addr_o   // palette address
);

    // ****************************************
    // carrier to the entry memory
    // ****************************************
    obpm_map_if mp ();

    obpm_map_mem u_mem (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .mp        (mp.mem)
    );

    // ****************************************
    // address decode
    // ****************************************
    logic       is_map;       // one of the sixteen map words
    logic       is_ctrl;      // mode control word
    logic       is_stat;      // status word
    logic       is_bad;       // nothing decodes
    logic       setup;        // apb setup cycle
    logic       access;       // apb access cycle
    logic [3:0] reg_idx;      // map register index

    assign reg_idx = paddr_i[obpm_pkg::REG_IDX_LSB +: obpm_pkg::REG_IDX_W];
    assign is_map  = (paddr_i >= obpm_pkg::MAP_BASE)
                   && (paddr_i < obpm_pkg::MAP_BASE + obpm_pkg::MAP_SPAN)
                   && (paddr_i[1:0] == 2'b00);
    assign is_ctrl = (paddr_i == obpm_pkg::CTRL_OFF);
    assign is_stat = (paddr_i == obpm_pkg::STAT_OFF);
    assign is_bad  = !(is_map || is_ctrl || is_stat);
    assign setup   = psel_i && !penable_i;
    assign access  = psel_i && penable_i;

    // ****************************************
    // read wait state
    // ****************************************
    obpm_pkg::obpm_apb_st_t st_r;   // read progress
    obpm_pkg::obpm_apb_st_t st_nxt;
    logic [31:0]            prdata_r;   // held read word
    logic [31:0]            prdata_nxt;

    // read: data registered in first access cycle, ready in second
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            obpm_pkg::ST_IDLE: begin
                if (access && !pwrite_i) begin
                    st_nxt = obpm_pkg::ST_RDONE;
                end
            end
            obpm_pkg::ST_RDONE: begin
                st_nxt = obpm_pkg::ST_IDLE;
            end
            default: begin
                st_nxt = obpm_pkg::ST_IDLE;
            end
        endcase
    end

    // state and read word registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_r     <= obpm_pkg::ST_IDLE;
            prdata_r <= '0;
        end else begin
            st_r     <= st_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign pready_o  = access && (pwrite_i || st_r == obpm_pkg::ST_RDONE);
    assign pslverr_o = pready_o && is_bad;
    assign prdata_o  = prdata_r;

    // ****************************************
    // control and status registers
    // ****************************************
    logic [3:0] ctrl_r;        // window modes
    logic [3:0] ctrl_nxt;
    logic [7:0] last_addr_r;   // last palette address sent
    logic       last_win_r;    // window of that address
    logic       wr_ctrl;       // ctrl write this edge

    assign wr_ctrl  = pready_o && pwrite_i && is_ctrl && pstrb_i[0];
    assign ctrl_nxt = wr_ctrl ? pwdata_i[3:0] : ctrl_r;

    // mode control, software steers the lookup
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl_r <= obpm_pkg::CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // read word: map pair, control, status; reserved bits zero
    always_comb begin
        prdata_nxt = prdata_r;
        if (access && !pwrite_i && st_r == obpm_pkg::ST_IDLE) begin
            prdata_nxt = '0;
            if (is_map) begin
                prdata_nxt[15:0] = mp.rd_data;
            end else if (is_ctrl) begin
                prdata_nxt[3:0] = ctrl_r;
            end else if (is_stat) begin
                prdata_nxt[7:0] = last_addr_r;
                prdata_nxt[obpm_pkg::STAT_WIN] = last_win_r;
            end
        end
    end

    // ****************************************
    // map port: bus side
    // ****************************************
    assign mp.wr_en   = pready_o && pwrite_i && is_map;
    assign mp.wr_reg  = reg_idx;
    assign mp.wr_strb = pstrb_i[1:0];
    assign mp.wr_data = pwdata_i[15:0];
    assign mp.rd_en   = setup && !pwrite_i && is_map;
    assign mp.rd_reg  = reg_idx;

    // ****************************************
    // pixel to entry
    // ****************************************
    // entry number for a pixel of the given depth
    function automatic logic [3:0] entry_of(
        input obpm_pkg::obpm_mode_t mode,
        input logic [3:0]           value
    );
        logic [3:0] e;
        e = value;
        case (mode)
            obpm_pkg::MODE_2BPP: begin
                case (value[1:0])
                    2'h1:    e = obpm_pkg::ENT_2B_ONE;
                    2'h2:    e = obpm_pkg::ENT_2B_TWO;
                    2'h3:    e = obpm_pkg::ENT_TOP;
                    default: e = obpm_pkg::ENT_ZERO;
                endcase
            end
            obpm_pkg::MODE_1BPP: begin
                e = value[0] ? obpm_pkg::ENT_TOP
                             : obpm_pkg::ENT_ZERO;
            end
            default: begin
                e = value;
            end
        endcase
        return e;
    endfunction : entry_of

    obpm_pkg::obpm_mode_t win_mode;  // mode of pixel's window
    logic [3:0]           ent_num;   // entry chosen

    assign win_mode = obpm_pkg::obpm_mode_t'(pix_win_i
        ? ctrl_r[obpm_pkg::CTRL_W1_LSB +: obpm_pkg::MODE_W]
        : ctrl_r[obpm_pkg::CTRL_W0_LSB +: obpm_pkg::MODE_W]);
    assign ent_num  = entry_of(win_mode, pix_value_i);
    assign mp.px_en  = pix_valid_i;
    assign mp.px_idx = {pix_win_i, ent_num};

    // ****************************************
    // colour lookup output
    // ****************************************
    logic px_win_d;    // window of pixel in flight

    // valid and window registered with the memory read, one cycle after the pixel
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            clut_valid_o <= 1'b0;
            px_win_d     <= 1'b0;
        end else begin
            clut_valid_o <= pix_valid_i;
            px_win_d     <= pix_win_i;
        end
    end

    assign clut_addr_o = mp.px_data;

    // status keeps the last address sent on
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            last_addr_r <= obpm_pkg::ENT_RST;
            last_win_r  <= 1'b0;
        end else if (clut_valid_o) begin
            last_addr_r <= mp.px_data;
            last_win_r  <= px_win_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_zero_entry: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        pix_valid_i && pix_value_i == 4'h0 |-> ent_num == 4'h0)
        else $error("pixel zero not mapped to entry 0");

    a_four_bit: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        pix_valid_i && win_mode == obpm_pkg::MODE_4BPP
            |-> ent_num == pix_value_i)
        else $error("4-bit pixel not mapped to its own entry");

    a_two_bit_one: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        pix_valid_i && win_mode == obpm_pkg::MODE_2BPP
            && pix_value_i[1:0] == 2'h1 |-> ent_num == 4'h5)
        else $error("2-bit value 1 not mapped to entry 5");

    a_two_bit_two: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        pix_valid_i && win_mode == obpm_pkg::MODE_2BPP
            && pix_value_i[1:0] == 2'h2 |-> ent_num == 4'ha)
        else $error("2-bit value 2 not mapped to entry 10");

    a_top_entry: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        pix_valid_i && ((win_mode == obpm_pkg::MODE_2BPP
            && pix_value_i[1:0] == 2'h3)
            || (win_mode == obpm_pkg::MODE_1BPP && pix_value_i[0]))
            |-> ent_num == 4'hf)
        else $error("top pixel value not mapped to entry 15");

    a_window_apart: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        pix_valid_i |-> mp.px_idx[4] == pix_win_i)
        else $error("pixel looked up in wrong window");

    a_lookup_valid: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        pix_valid_i |=> clut_valid_o ##1 last_addr_r == $past(clut_addr_o))
        else $error("palette address not sent one cycle on");

    a_reserved_zero: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        pready_o && !pwrite_i && is_map |-> prdata_o[31:16] == 16'h0000)
        else $error("reserved bits of a map word not zero");

    a_read_two_cycles: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        setup && !pwrite_i ##1 access && $stable(paddr_i)
            |-> !pready_o ##1 (pready_o || !access))
        else $error("read answer not in second access cycle");

    // ****************************************
    // bus and output checks
    // ****************************************
    // writes never wait
    a_write_no_wait: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        access && pwrite_i |-> pready_o)
        else $error("write not answered in first access cycle");

    // a refused transfer touches no register
    a_bad_no_write: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        pslverr_o |-> !mp.wr_en && !wr_ctrl)
        else $error("refused transfer changed a register");

    // modes move only on a control write
    a_ctrl_hold: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        !wr_ctrl |=> ctrl_r == $past(ctrl_r))
        else $error("mode control changed without a write");

    // one palette strobe per pixel, one cycle on
    a_clut_pulse: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        clut_valid_o == $past(pix_valid_i))
        else $error("palette valid not one cycle after pixel");

    // unused control bits read as zero
    a_ctrl_upper: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        pready_o && !pwrite_i && is_ctrl |-> prdata_o[31:4] == 28'h0)
        else $error("unused control bits not zero");

    // status keeps the window of the address sent
    a_stat_window: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        clut_valid_o |=> last_win_r == $past(px_win_d))
        else $error("status window not the window of the lookup");

endmodule : obpm_top

`default_nettype wire

// ---- testbench/obpm_clut_model.sv ----
// colour lookup stage model that sits after the palette map block
// assumes clut_* come from registers of the block on clk_sys_i
`default_nettype none

module obpm_clut_model (
    input  wire logic        clk_sys_i,    // system clock
    input  wire logic        rst_n_i,      // synchronous reset, low
    input  wire logic        clut_valid_i, // palette address valid
    input  wire logic [7:0]  clut_addr_i,  // palette address
    output logic      [7:0]  last_addr_o,  // last address taken
    output logic      [15:0] n_taken_o     // addresses taken so far
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // table side
    // ****************************************
    // takes one address per valid cycle, never pushes back
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            last_addr_o <= 8'h00;
            n_taken_o   <= 16'h0000;
        end else if (clut_valid_i) begin
            last_addr_o <= clut_addr_i;
            n_taken_o   <= n_taken_o + 16'h0001;
        end
    end
endmodule : obpm_clut_model

`default_nettype wire

// ---- testbench/obpm_top_tb.sv ----
// self-checking bench for the bitmap palette map register bank
// assumes obpm_top, obpm_pkg and the colour lookup model are compiled
`default_nettype none

module obpm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic        clk_sys_i;    // 100 MHz clock
    logic        rst_n_i;      // synchronous reset, low
    logic [11:0] paddr_i;      // apb byte address
    logic        psel_i;       // apb select
    logic        penable_i;    // apb access phase
    logic        pwrite_i;     // apb direction
    logic [31:0] pwdata_i;     // apb write data
    logic [3:0]  pstrb_i;      // apb byte strobes
    logic [31:0] prdata_o;     // apb read data
    logic        pready_o;     // apb ready
    logic        pslverr_o;    // apb error
    logic        pix_valid_i;  // pixel present
    logic        pix_win_i;    // pixel window
    logic [3:0]  pix_value_i;  // pixel value
    logic        clut_valid_o; // palette address valid
    logic [7:0]  clut_addr_o;  // palette address
    logic [7:0]  last_addr;    // model: last address
    logic [15:0] n_taken;      // model: addresses taken
    logic [31:0] rdat;         // data of last read
    int          n_errors;     // mismatches
    int          tests_run;    // comparisons
    int          n_pix;        // pixels sent

    obpm_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pix_valid_i(pix_valid_i), .pix_win_i(pix_win_i),
        .pix_value_i(pix_value_i), .clut_valid_o(clut_valid_o),
        .clut_addr_o(clut_addr_o));

    obpm_clut_model u_clut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .clut_valid_i(clut_valid_o), .clut_addr_i(clut_addr_o),
        .last_addr_o(last_addr), .n_taken_o(n_taken));

    // ****************************************
    // helpers
    // ****************************************
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // compare a data value
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk32

    // compare a flag
    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk1

    // one apb transfer; waits for pready, checks the error flag
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       input logic exp_err);
        int i;
        @(posedge clk_sys_i);
        psel_i    <= 1'b1;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        pstrb_i   <= s;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        // pready, read data and error taken at the completing rising edge
        for (i = 0; i < 16; i++) begin
            @(posedge clk_sys_i);
            if (pready_o === 1'b1) break;
        end
        if (i == 16) begin
            n_errors++;
            end_of_test();
        end
        rdat = prdata_o;
        chk1(pslverr_o, exp_err);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    // one pixel, answer checked the cycle after it is taken
    task automatic pix(input logic w, input logic [3:0] v,
                       input logic [7:0] exp);
        @(posedge clk_sys_i);
        pix_valid_i <= 1'b1;
        pix_win_i   <= w;
        pix_value_i <= v;
        @(posedge clk_sys_i);
        pix_valid_i <= 1'b0;
        @(negedge clk_sys_i);
        n_pix++;
        chk1(clut_valid_o, 1'b1);
        chk32({24'h0, clut_addr_o}, {24'h0, exp});
    endtask : pix

    // distinct test value for each of the 32 entries
    function automatic logic [7:0] ent_val(input int w, input int e);
        return 8'((w * 16 + e) * 37 + 5);
    endfunction : ent_val

    // entry number chosen by a pixel value in a pixel mode
    function automatic logic [3:0] ent_of(input logic [1:0] m,
                                          input logic [3:0] v);
        case (m)
            2'b01:   return 4'(v[1:0] * 5);
            2'b10:   return v[0] ? 4'hf : 4'h0;
            default: return v;
        endcase
    endfunction : ent_of

    // ****************************************
    // clock
    // ****************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_n_i = 1'b0;
        {psel_i, penable_i, pwrite_i, pix_valid_i, pix_win_i} = 5'h00;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        pstrb_i = 4'h0;
        pix_value_i = 4'h0;
        n_errors = 0;
        tests_run = 0;
        n_pix = 0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // every map word starts at zero
        for (int n = 0; n < 16; n++) begin
            apb(1'b0, 12'(4 * n), 32'h0, 4'h0, 1'b0);
            chk32(rdat, 32'h0);
        end
        // fill all entries, reserved bits written high
        for (int n = 0; n < 16; n++) begin
            apb(1'b1, 12'(4 * n), {16'hffff, ent_val(n / 8, 2 * (n % 8) + 1),
                ent_val(n / 8, 2 * (n % 8))}, 4'hf, 1'b0);
        end
        for (int n = 0; n < 16; n++) begin
            apb(1'b0, 12'(4 * n), 32'h0, 4'h0, 1'b0);
            chk32(rdat, {16'h0, ent_val(n / 8, 2 * (n % 8) + 1),
                ent_val(n / 8, 2 * (n % 8))});
        end
        // odd entry alone by strobe, then restore
        apb(1'b1, 12'h004, 32'h0000_aa55, 4'b0010, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 4'h0, 1'b0);
        chk32(rdat, {16'h0, 8'haa, ent_val(0, 2)});
        apb(1'b1, 12'h004, {16'h0, ent_val(0, 3), ent_val(0, 2)}, 4'hf, 1'b0);
        // unmapped read and misaligned write are refused
        apb(1'b0, 12'h048, 32'h0, 4'h0, 1'b1);
        chk32(rdat, 32'h0);
        apb(1'b1, 12'h002, 32'h0000_ffff, 4'hf, 1'b1);
        apb(1'b0, 12'h000, 32'h0, 4'h0, 1'b0);
        chk32(rdat, {16'h0, ent_val(0, 1), ent_val(0, 0)});
        // every mode, windows in different modes, all pixel values
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, obpm_pkg::CTRL_OFF, {28'h0, 2'(m), 2'(3 - m)},
                4'h1, 1'b0);
            for (int w = 0; w < 2; w++) begin
                for (int v = 0; v < 16; v++) begin
                    pix(w[0], 4'(v), ent_val(w, ent_of(
                        w ? 2'(m) : 2'(3 - m), 4'(v))));
                end
            end
        end
        // status ignores writes, names the last address and its window
        apb(1'b1, obpm_pkg::STAT_OFF, 32'hffff_ffff, 4'hf, 1'b0);
        apb(1'b0, obpm_pkg::STAT_OFF, 32'h0, 4'h0, 1'b0);
        chk32(rdat, {23'h0, 1'b1, ent_val(1, 15)});
        // last mode pair reads back, unused bits zero
        apb(1'b0, obpm_pkg::CTRL_OFF, 32'h0, 4'h0, 1'b0);
        chk32(rdat, 32'h0000_000c);
        // the lookup stage saw one address per pixel, the last one last
        chk32({16'h0, n_taken}, 32'(n_pix));
        chk32({24'h0, last_addr}, {24'h0, ent_val(1, 15)});
        end_of_test();
    end
endmodule : obpm_top_tb

`default_nettype wire
